/* File: hbp_dev.sv */
// Operation
// - start only with select and strobe low
// - drive data and ack only when selected
// - host holds address during strobe
// - read data driven during read strobe
// - data undriven out of reset
// - even parity per byte, same drive (code drops the parity drive while the skip strap is set)
// - host strobe marks start, idle after reset
// - direction line picks who drives data
// - strap inverts direction meaning
// - ack, then inactive one cycle, release
// - ack released out of reset
// - strap picks ack polarity
// - error only with ack, on bad parity
// - open-drain interrupt low on error
// - strap skips write parity checking
// - all logic on host bus clock (code runs all logic on clk_sys, with pins passed through hbp_sync)
// - tx_space_n low while queue accepts
// - rx_avail_n low while receive data waits
// - pulse frame end per received frame
//
// switch end of the host port with a small register file
// assumes pins arrive asynchronously and pass hbp_sync first
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module hbp_dev
  import hbp_pkg::*;
#(
  parameter int REG_N = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  hbp_if.dev bus,
  input wire logic int_error,
  input wire logic tx_queue_room,
  input wire logic rx_queue_data,
  input wire logic rx_frame_done,
  output logic err_irq_pending,
  output logic [DATA_W-1:0] reg0_value
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 3 + ADDR_W + DATA_W + PAR_W + 3;
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic [SW-1:0] syn_rst;
  logic s_cs_n;
  logic s_as_n;
  logic s_dir;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  logic [PAR_W-1:0] s_par;
  logic s_dir_inv;
  logic s_ack_inv;
  logic s_skip;
  assign raw = {bus.chip_sel_n, bus.addr_strobe_n, bus.dir_select_n, bus.addr,
                bus.data_bus, bus.par_bus, bus.dir_polarity_strap,
                bus.ack_polarity_strap, bus.skip_check_strap};
  // select and strobe idle high after reset
  assign syn_rst = {2'b11, {(SW-2){1'b0}}};
  hbp_sync #(.W(SW)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d(raw),
    .rst_val(syn_rst),
    .q(syn)
  );
  assign {s_cs_n, s_as_n, s_dir, s_addr, s_data, s_par, s_dir_inv, s_ack_inv, s_skip} = syn;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_END = 2'b11,
    ST_WAIT = 2'b10
  } dstate_t;
  dstate_t state;
  dstate_t next_state;
  logic [DATA_W-1:0] regs [REG_N];
  logic as_q;
  logic is_read;
  logic start;
  logic par_bad;
  logic [$clog2(REG_N)-1:0] idx;
  logic [DATA_W-1:0] rd_word;
  logic selected;
  assign is_read = s_dir ^ s_dir_inv;
  assign selected = ~s_cs_n;
  // start needs select and a fresh strobe
  assign start = selected & ~s_as_n & as_q;
  assign idx = s_addr[$clog2(REG_N)-1:0];
  assign rd_word = regs[idx];
  assign par_bad = ~s_skip & (even_par(s_data) != s_par);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start) next_state = ST_ACK;
      ST_ACK: if (s_as_n | ~selected) next_state = ST_END;
      ST_END: next_state = ST_IDLE;
      ST_WAIT: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // transaction engine
  // ----------------------------------------------------------------
  logic ack_act;
  logic wr_err;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_WAIT;
      as_q <= 1'b0;
      ack_act <= 1'b0;
      wr_err <= 1'b0;
      bus.data_dev <= '0;
      bus.par_dev <= '0;
    end else begin
      state <= next_state;
      as_q <= s_as_n;
      if (state == ST_IDLE && start) begin
        ack_act <= 1'b1;
        if (is_read) begin
          bus.data_dev <= rd_word;
          bus.par_dev <= even_par(rd_word);
          wr_err <= 1'b0;
        end else begin
          wr_err <= par_bad;
        end
      end else if (state == ST_ACK && next_state == ST_END) begin
        ack_act <= 1'b0;
        wr_err <= 1'b0;
      end
    end
  end

  // register file; the write is dropped only on bad parity with the skip strap low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < REG_N; i++) regs[i] <= RESET_WORD;
    end else if (state == ST_IDLE && start && !is_read && !par_bad) begin
      regs[idx] <= s_data;
    end
  end
  assign reg0_value = regs[0];

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic rd_drive;
  logic ack_drive;
  // read data only during a live read
  assign rd_drive = (state == ST_ACK) & is_read & selected & ~s_as_n;
  // ack driven in ack and one end cycle
  assign ack_drive = selected & ((state == ST_ACK) | (state == ST_END));
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus.data_dev_oe <= 1'b0;
      bus.par_dev_oe <= 1'b0;
      bus.ack_oe <= 1'b0;
      bus.ack_out <= 1'b0;
      bus.err_oe <= 1'b0;
      bus.err_out <= 1'b1;
    end else begin
      bus.data_dev_oe <= rd_drive;
      // parity follows data; optional under skip strap
      bus.par_dev_oe <= rd_drive & ~s_skip;
      bus.ack_oe <= ack_drive;
      // polarity from strap, active level only in ack state
      bus.ack_out <= (ack_act & (state == ST_ACK)) ^ ~s_ack_inv;
      // error driven only alongside active ack
      bus.err_oe <= selected & (state == ST_ACK) & wr_err;
      bus.err_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and dma handshake
  // ----------------------------------------------------------------
  logic rx_done_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus.irq_oe <= 1'b0;
      bus.tx_space_n <= 1'b1;
      bus.rx_avail_n <= 1'b1;
      bus.frame_end_out <= 1'b0;
      rx_done_q <= 1'b0;
      err_irq_pending <= 1'b0;
    end else begin
      // open drain pulls low on internal error
      bus.irq_oe <= int_error;
      err_irq_pending <= int_error;
      bus.tx_space_n <= ~tx_queue_room;
      bus.rx_avail_n <= ~rx_queue_data;
      rx_done_q <= rx_frame_done;
      // one pulse per frame end edge
      bus.frame_end_out <= rx_frame_done & ~rx_done_q;
    end
  end
endmodule : hbp_dev
`default_nettype wire

/* File: hbp_pkg.sv */
// shared constants and types for the parallel host bus port
// assumes both ends run on one clock, clk_sys, with synchronous srst
package hbp_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  // host port clock ceiling and our own clock, in MHz
  localparam int HOST_CLK_MAX_MHZ = 100;
  localparam int SYS_CLK_MHZ = 125;
  // host divides clk_sys down to a port rate below the ceiling
  localparam int PORT_DIV = (SYS_CLK_MHZ + HOST_CLK_MAX_MHZ - 1) / HOST_CLK_MAX_MHZ;
  // wishbone register offsets of the host controller (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // ctrl bits: 0 go (self clear), 1 write, 2 corrupt parity
  localparam int CTRL_GO = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_BADPAR = 2;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_IRQ = 3;
  localparam int ST_TXSP = 4;
  localparam int ST_RXAV = 5;
  localparam int ST_EOF = 6;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  function automatic logic [PAR_W-1:0] even_par(input logic [DATA_W-1:0] d);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction : even_par
endpackage : hbp_pkg

/* File: hbp_if.sv */
// pin bundle between the switch host port and the external host
// assumes the bench resolves two-way pins from the enables
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
  import hbp_pkg::*;
  logic port_clk;
  logic chip_sel_n;
  logic addr_strobe_n;
  logic dir_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_dev;
  logic [DATA_W-1:0] data_host;
  logic data_dev_oe;
  logic data_host_oe;
  logic [DATA_W-1:0] data_bus;
  logic [PAR_W-1:0] par_dev;
  logic [PAR_W-1:0] par_host;
  logic par_dev_oe;
  logic par_host_oe;
  logic [PAR_W-1:0] par_bus;
  logic ack_out;
  logic ack_oe;
  logic ack_bus;
  logic err_out;
  logic err_oe;
  logic err_bus;
  logic irq_oe;
  logic tx_space_n;
  logic rx_avail_n;
  logic frame_end_out;
  logic dir_polarity_strap;
  logic ack_polarity_strap;
  logic skip_check_strap;
  modport dev (
    input port_clk, chip_sel_n, addr_strobe_n, dir_select_n, addr, data_bus, par_bus,
    input dir_polarity_strap, ack_polarity_strap, skip_check_strap,
    output data_dev, data_dev_oe, par_dev, par_dev_oe, ack_out, ack_oe, err_out, err_oe,
    output irq_oe, tx_space_n, rx_avail_n, frame_end_out
  );
  modport host (
    output port_clk, chip_sel_n, addr_strobe_n, dir_select_n, addr,
    output data_host, data_host_oe, par_host, par_host_oe,
    input data_bus, par_bus, ack_bus, err_bus, irq_oe, tx_space_n, rx_avail_n,
    input frame_end_out, dir_polarity_strap, ack_polarity_strap, skip_check_strap
  );
endinterface : hbp_if
`default_nettype wire

/* File: hbp_sync.sv */
// two-flop synchroniser for pin-level inputs
// assumes the destination runs on clk_sys
`timescale 1ns/1ps
`default_nettype none
module hbp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // the first stage feeds the second stage only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d ^ rst_val;
      q <= meta ^ rst_val;
    end
  end
endmodule : hbp_sync
`default_nettype wire

/* File: hbp_host.sv */
// host end: wishbone slave registers drive one port transaction
// assumes device pins return through hbp_sync; port clock from a divider
`timescale 1ns/1ps
`default_nettype none
module hbp_host
  import hbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  hbp_if.host bus,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // ----------------------------------------------------------------
  // returned pins
  // ----------------------------------------------------------------
  localparam int RW = DATA_W + 6;
  logic [RW-1:0] s_in;
  logic [DATA_W-1:0] s_data;
  logic s_ack;
  logic s_err;
  logic s_irq;
  logic s_tx;
  logic s_rx;
  logic s_eof;
  // ack is made active high before the sync, so a strap change never looks like an ack
  hbp_sync #(.W(RW)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d({bus.data_bus, ~(bus.ack_bus ^ bus.ack_polarity_strap), bus.err_bus, bus.irq_oe,
        bus.tx_space_n, bus.rx_avail_n, bus.frame_end_out}),
    .rst_val({{DATA_W{1'b0}}, 6'b010_110}),
    .q(s_in)
  );
  assign {s_data, s_ack, s_err, s_irq, s_tx, s_rx, s_eof} = s_in;

  // ----------------------------------------------------------------
  // control registers and transaction fsm
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_REQ = 2'b01,
    H_REL = 2'b11
  } hstate_t;
  hstate_t state;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr_r;
  logic bad_r;
  logic done;
  logic err;
  logic eof_seen;
  logic [3:0] div;
  logic wb_hit;
  logic go;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign go = wb_hit & wb_we_i & (wb_adr_i == REG_CTRL) & wb_dat_i[CTRL_GO] & (state == H_IDLE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= H_IDLE;
      addr_r <= '0;
      wdata <= '0;
      rdata <= '0;
      wr_r <= 1'b0;
      bad_r <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      eof_seen <= 1'b0;
      div <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      bus.port_clk <= 1'b0;
      bus.chip_sel_n <= 1'b1;
      bus.addr_strobe_n <= 1'b1;
      bus.dir_select_n <= 1'b1;
      bus.addr <= '0;
      bus.data_host <= '0;
      bus.data_host_oe <= 1'b0;
      bus.par_host <= '0;
      bus.par_host_oe <= 1'b0;
    end else begin
      // port clock divided below its ceiling
      div <= (div == 4'(PORT_DIV - 1)) ? '0 : div + 4'd1;
      bus.port_clk <= (div < 4'(PORT_DIV / 2)) ? 1'b0 : 1'b1;
      wb_ack_o <= wb_hit;
      if (wb_hit && wb_we_i && wb_adr_i == REG_ADDR) addr_r <= wb_dat_i[ADDR_W+1:2];
      if (wb_hit && wb_we_i && wb_adr_i == REG_WDATA) wdata <= wb_dat_i;
      unique case (wb_adr_i)
        REG_ADDR: wb_dat_o <= {8'h00, addr_r, 2'b00};
        REG_WDATA: wb_dat_o <= wdata;
        REG_RDATA: wb_dat_o <= rdata;
        REG_STATUS: wb_dat_o <= {25'h0, eof_seen, ~s_rx, ~s_tx, s_irq, err, done,
                                 state != H_IDLE};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
      // event flag: set beats the clear-on-read
      if (s_eof) eof_seen <= 1'b1;
      else if (wb_hit && !wb_we_i && wb_adr_i == REG_STATUS) eof_seen <= 1'b0;
      unique case (state)
        H_IDLE: if (go) begin
          wr_r <= wb_dat_i[CTRL_WR];
          bad_r <= wb_dat_i[CTRL_BADPAR];
          done <= 1'b0;
          err <= 1'b0;
          bus.chip_sel_n <= 1'b0;
          bus.addr_strobe_n <= 1'b0;
          bus.addr <= addr_r;
          bus.dir_select_n <= ~wb_dat_i[CTRL_WR] ^ bus.dir_polarity_strap;
          bus.data_host <= wdata;
          // even parity, optionally spoiled to test errors
          bus.par_host <= even_par(wdata) ^ {3'b000, wb_dat_i[CTRL_BADPAR]};
          // write data driven for the whole request
          bus.data_host_oe <= wb_dat_i[CTRL_WR];
          bus.par_host_oe <= wb_dat_i[CTRL_WR];
          state <= H_REQ;
        end
        H_REQ: if (s_ack) begin
          rdata <= s_data;
          // error pin is active low with a pull-up
          err <= ~s_err;
          bus.addr_strobe_n <= 1'b1;
          state <= H_REL;
        end
        H_REL: if (!s_ack) begin
          // write data held while ack stands
          bus.data_host_oe <= 1'b0;
          bus.par_host_oe <= 1'b0;
          bus.chip_sel_n <= 1'b1;
          done <= 1'b1;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : hbp_host
`default_nettype wire

/* File: host_cpu_bus_port_chk.sv */
// checker on the port pins between the host end and the switch end
// assumes one clock, sync reset, straps changed only while the port is idle
`timescale 1ns/1ps
`default_nettype none
module host_cpu_bus_port_chk
  import hbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [DATA_W-1:0] data_bus,
  input wire logic [PAR_W-1:0] par_bus,
  input wire logic chip_sel_n,
  input wire logic addr_strobe_n,
  input wire logic dir_select_n,
  input wire logic data_dev_oe,
  input wire logic par_dev_oe,
  input wire logic ack_out,
  input wire logic ack_oe,
  input wire logic err_out,
  input wire logic err_oe,
  input wire logic frame_end_out,
  input wire logic dir_polarity_strap,
  input wire logic ack_polarity_strap,
  input wire logic skip_check_strap
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ------------------------------
  // ack phases, pin level set by strap
  // ------------------------------
  sequence s_ack_on;
    ack_oe && ack_out == ack_polarity_strap;
  endsequence
  sequence s_ack_off;
    ack_oe && ack_out != ack_polarity_strap;
  endsequence
  a_start_needs_sel: assert property ($rose(ack_oe) |-> !chip_sel_n && !addr_strobe_n)
    else $error("ack began without select and strobe");
  a_drive_when_sel: assert property ((ack_oe || data_dev_oe) |-> !chip_sel_n)
    else $error("pins driven while not selected");
  a_data_read_only: assert property (data_dev_oe |-> s_ack_on and
    (dir_select_n ^ dir_polarity_strap))
    else $error("data driven outside an acknowledged read");
  a_par_follows_data: assert property (par_dev_oe |-> data_dev_oe)
    else $error("parity driven without data");
  a_read_parity: assert property (par_dev_oe |-> par_bus ==
    {^data_bus[31:24], ^data_bus[23:16], ^data_bus[15:8], ^data_bus[7:0]})
    else $error("read parity not even per byte");
  a_ack_tail_once: assert property (s_ack_on ##1 s_ack_off |=> !ack_oe)
    else $error("ack not released after one idle cycle");
  a_tail_after_on: assert property (s_ack_off |->
    $past(ack_oe && ack_out == ack_polarity_strap))
    else $error("idle ack level without active phase");
  a_ack_bounded: assert property ($fell(addr_strobe_n) && !chip_sel_n |->
    ##[1:16] s_ack_on)
    else $error("no ack after strobe");
  a_err_with_ack: assert property (err_oe |-> s_ack_on and !err_out)
    else $error("error driven outside active ack");
  a_skip_no_err: assert property (skip_check_strap |-> !err_oe)
    else $error("error flagged with checking skipped");
  a_reset_quiet: assert property ($fell(srst) |->
    (!ack_oe && !data_dev_oe && !err_oe)[*2])
    else $error("pins driven out of reset");
  a_frame_pulse: assert property (frame_end_out |=> !frame_end_out)
    else $error("frame end longer than one cycle");
endmodule : host_cpu_bus_port_chk
`default_nettype wire

/* File: host_cpu_bus_port_test.sv */
// testbench: host end and switch end joined by the port interface
// assumes software reaches the port only through the host end wishbone
`timescale 1ns/1ps
`default_nettype none
module host_cpu_bus_port_test;
  import hbp_pkg::*;
  logic clk_sys, srst, cyc, stb, we, wb_ack, irq_out_n;
  logic int_error, tx_queue_room, rx_queue_data, rx_frame_done, err_irq_pending;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, reg0_value, st, q, d;
  int fails, checks;
  hbp_if bus ();
  // ------------------------------
  // pin resolution: pull-down data, idle ack level, pull-up error and irq
  // ------------------------------
  assign bus.data_bus = bus.data_dev_oe ? bus.data_dev : (bus.data_host_oe ? bus.data_host : '0);
  assign bus.par_bus = bus.par_dev_oe ? bus.par_dev : (bus.par_host_oe ? bus.par_host : '0);
  assign bus.ack_bus = bus.ack_oe ? bus.ack_out : ~bus.ack_polarity_strap;
  assign bus.err_bus = bus.err_oe ? bus.err_out : 1'b1;
  assign irq_out_n = bus.irq_oe ? 1'b0 : 1'b1;
  hbp_dev hbp_dev_i (.clk_sys(clk_sys), .srst(srst), .bus(bus), .int_error(int_error),
    .tx_queue_room(tx_queue_room), .rx_queue_data(rx_queue_data),
    .rx_frame_done(rx_frame_done), .err_irq_pending(err_irq_pending), .reg0_value(reg0_value));
  hbp_host hbp_host_i (.clk_sys(clk_sys), .srst(srst), .bus(bus), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(wb_ack));
  host_cpu_bus_port_chk host_cpu_bus_port_chk_i (.clk_sys(clk_sys), .srst(srst),
    .data_bus(bus.data_bus), .par_bus(bus.par_bus),
    .chip_sel_n(bus.chip_sel_n), .addr_strobe_n(bus.addr_strobe_n),
    .dir_select_n(bus.dir_select_n), .data_dev_oe(bus.data_dev_oe),
    .par_dev_oe(bus.par_dev_oe), .ack_out(bus.ack_out), .ack_oe(bus.ack_oe),
    .err_out(bus.err_out), .err_oe(bus.err_oe), .frame_end_out(bus.frame_end_out),
    .dir_polarity_strap(bus.dir_polarity_strap), .ack_polarity_strap(bus.ack_polarity_strap),
    .skip_check_strap(bus.skip_check_strap));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic hang(input string what);
    fails++;
    $display("MISMATCH t=%0t timeout %s", $time, what);
    close_out();
  endtask : hang
  // one classic cycle; a wait cut short ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
      output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) hang("wishbone");
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // one port transfer, then poll status until idle and done
  task automatic txn(input logic w, input logic bad, input logic [7:0] ba, input logic [31:0] v);
    int n;
    wb(1'b1, REG_ADDR, {24'h00_0000, ba}, q);
    wb(1'b1, REG_WDATA, v, q);
    wb(1'b1, REG_CTRL, {29'h0000_0000, bad, w, 1'b1}, q);
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0000_0000, st);
      n++;
    end while (!(st[ST_BUSY] === 1'b0 && st[ST_DONE] === 1'b1) && n < 100);
    if (n >= 100) hang("port transfer");
  endtask : txn
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    chk({31'h0, bus.data_dev_oe | bus.par_dev_oe}, 32'h0, "data oe at reset");
    chk({31'h0, bus.ack_oe | bus.err_oe}, 32'h0, "ack oe at reset");
    chk({30'h0, bus.tx_space_n, bus.rx_avail_n}, 32'h3, "dma idle");
    chk({30'h0, bus.chip_sel_n, bus.addr_strobe_n}, 32'h3, "host idle");
    q[0] = bus.port_clk;
    @(posedge clk_sys);
    chk({31'h0, bus.port_clk ^ q[0]}, 32'h1, "port clock runs");
  endtask : t_reset
  task automatic t_strap_rw();
    for (int i = 0; i < 4; i++) begin
      bus.dir_polarity_strap <= i[0];
      bus.ack_polarity_strap <= i[1];
      repeat (4) @(posedge clk_sys);
      d = 32'hc3a5_5a00 | 32'(i);
      txn(1'b1, 1'b0, 8'h00, d);
      chk(reg0_value, d, "write reg0");
      txn(1'b1, 1'b0, 8'h14, ~d);
      txn(1'b0, 1'b0, 8'h14, 32'h0000_0000);
      wb(1'b0, REG_RDATA, 32'h0000_0000, q);
      chk(q, ~d, "read back");
      chk({31'h0, st[ST_ERR]}, 32'h0, "no error");
    end
  endtask : t_strap_rw
  task automatic t_parity();
    bus.skip_check_strap <= 1'b1;
    repeat (4) @(posedge clk_sys);
    txn(1'b1, 1'b1, 8'h00, 32'h1111_2222);
    chk(reg0_value, 32'h1111_2222, "skip keeps write");
    chk({31'h0, st[ST_ERR]}, 32'h0, "skip no error");
    bus.skip_check_strap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    txn(1'b1, 1'b1, 8'h00, 32'h3333_4444);
    chk(reg0_value, 32'h1111_2222, "bad write dropped");
    chk({31'h0, st[ST_ERR]}, 32'h1, "error seen");
  endtask : t_parity
  task automatic t_dma();
    int n;
    tx_queue_room <= 1'b1;
    rx_queue_data <= 1'b1;
    int_error <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({29'h0, bus.tx_space_n, bus.rx_avail_n, irq_out_n}, 32'h0, "dma low");
    chk({31'h0, err_irq_pending}, 32'h1, "irq pending");
    wb(1'b0, REG_STATUS, 32'h0000_0000, st);
    chk({29'h0, st[5:3]}, 32'h7, "status levels");
    tx_queue_room <= 1'b0;
    rx_queue_data <= 1'b0;
    int_error <= 1'b0;
    rx_frame_done <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bus.frame_end_out !== 1'b1 && n < 10);
    chk({31'h0, bus.frame_end_out}, 32'h1, "frame end");
    @(posedge clk_sys);
    chk({31'h0, bus.frame_end_out}, 32'h0, "frame end once");
    rx_frame_done <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({29'h0, bus.tx_space_n, bus.rx_avail_n, irq_out_n}, 32'h7, "dma high");
    wb(1'b0, REG_STATUS, 32'h0000_0000, st);
    chk({31'h0, st[ST_EOF]}, 32'h1, "eof seen");
    wb(1'b0, REG_STATUS, 32'h0000_0000, st);
    chk({31'h0, st[ST_EOF]}, 32'h0, "eof cleared");
    wb(1'b0, 8'h20, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "unmapped read");
  endtask : t_dma
  initial begin
    fails = 0;
    checks = 0;
    srst = 1'b1;
    {cyc, stb, we, int_error, tx_queue_room, rx_queue_data, rx_frame_done} = 7'h00;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    bus.dir_polarity_strap = 1'b0;
    bus.ack_polarity_strap = 1'b0;
    bus.skip_check_strap = 1'b0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_strap_rw();
    t_parity();
    t_dma();
    close_out();
  end
endmodule : host_cpu_bus_port_test
`default_nettype wire
